// >>> common/sleep_pkg.sv
package sleep_pkg;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLOCK_HZ = 20_000_000; // core clock rate
  localparam int TICK_US = 1; // watchdog time base, microseconds
  localparam int TICK_CYCLES = CLOCK_HZ / 1_000_000 * TICK_US; // cycles per tick
  localparam int WATCHDOG_PERIOD_US = 18000; // nominal time-out
  localparam int WATCHDOG_TICKS = WATCHDOG_PERIOD_US / TICK_US; // ticks per time-out
  localparam int WAKE_RESET_US = 300; // reset hold after a wake or reset
  localparam int WAKE_RESET_TICKS = WAKE_RESET_US / TICK_US; // ticks of reset hold
  // ***********************************************************
  // register map, byte addresses
  // ***********************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] WATCHDOG_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h10;
  // control fields
  localparam int CTRL_WATCHDOG_EN_BIT = 0;
  localparam int CTRL_WAKE_CHANGE_BIT = 1;
  localparam int CTRL_MASTER_CLEAR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;
  // status fields
  localparam int STATUS_ASLEEP_BIT = 0;
  localparam int STATUS_POWERDOWN_BIT = 3;
  localparam int STATUS_TIMEOUT_BIT = 4;
  localparam int STATUS_PIN_WAKE_BIT = 7;
  // interrupt event fields
  localparam int IRQ_SLEEP_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_WATCHDOG_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  // ***********************************************************
  // types
  // ***********************************************************
  typedef struct packed {
    logic pin_wake; // wake came from a pin change
    logic timeout; // low after a watchdog time-out
    logic powerdown; // low after sleep
  } flags_t;
  localparam flags_t FLAGS_POWER_UP = 3'b011;
  typedef struct packed {
    logic [5:0] level; // value driven on each pin
    logic [5:0] oe_n; // low while the pin is driven
  } pin_drive_t;
  localparam pin_drive_t PIN_DRIVE_RESET = 12'h03F;
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_RESET = 3'b100
  } state_t;
endpackage

// >>> verilog/wake_watchdog.sv
module wake_watchdog #(
  parameter int TICK_CYCLES = 20,
  parameter int TIMEOUT_TICKS = 18000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic clear,
  // status
  output logic tick,
  output logic [15:0] count,
  output logic timeout
);
  initial begin
    if (TICK_CYCLES < 1 || TIMEOUT_TICKS < 2 || TIMEOUT_TICKS > 65535) begin
      $error("wake_watchdog: unsupported parameters");
    end
  end
  logic [15:0] divider; // time-base divider
  // time base runs always, like a separate oscillator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divider <= 16'h0000;
      tick <= 1'b0;
    end else if (divider == 16'(TICK_CYCLES - 1)) begin
      divider <= 16'h0000;
      tick <= 1'b1;
    end else begin
      divider <= divider + 16'h0001;
      tick <= 1'b0;
    end
  end
  // counter; clear beats a tick so a cleared count starts from zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      timeout <= 1'b0;
    end else if (clear || !enable) begin
      count <= 16'h0000;
      timeout <= 1'b0;
    end else if (tick && count == 16'(TIMEOUT_TICKS - 1)) begin
      count <= 16'h0000;
      timeout <= 1'b1;
    end else begin
      count <= tick ? count + 16'h0001 : count;
      timeout <= 1'b0;
    end
  end
endmodule

// >>> verilog/pin_change_detect.sv
module pin_change_detect #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // pins and capture strobe
  input wire logic [WIDTH-1:0] pins,
  input wire logic capture,
  // result
  output logic changed
);
  initial begin
    if (WIDTH < 1) begin
      $error("pin_change_detect: WIDTH must be positive");
    end
  end
  logic [WIDTH-1:0] snapshot; // pins at the last port access
  // snapshot taken on every file or bit operation on the port
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snapshot <= '0;
    end else if (capture) begin
      snapshot <= pins;
    end
  end
  // a stale snapshot makes this true with no pin moving
  assign changed = (pins != snapshot);
endmodule

// >>> verilog/sleep_wakeup_control.sv
module sleep_wakeup_control #(
  parameter int WATCHDOG_TICKS = sleep_pkg::WATCHDOG_TICKS,
  parameter int WAKE_RESET_TICKS = sleep_pkg::WAKE_RESET_TICKS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // core events
  input wire logic sleep_exec,
  input wire logic clrwdt_exec,
  input wire logic port_access,
  // core pin drive, and frozen drive to the pads
  input wire sleep_pkg::pin_drive_t core_drive,
  output sleep_pkg::pin_drive_t pad_drive,
  // monitored inputs and master clear
  input wire logic port_input_zero,
  input wire logic port_input_one,
  input wire logic port_input_three,
  input wire logic master_clear_pin_n,
  output logic master_clear_oe_n,
  // core control
  output logic osc_drive_en,
  output logic cpu_clock_en,
  output logic fetch_hold,
  output logic device_reset_n,
  output sleep_pkg::flags_t flags,
  // interrupt
  output logic irq
);
  initial begin
    if (WATCHDOG_TICKS < 2 || WAKE_RESET_TICKS < 1 || WAKE_RESET_TICKS > 65535) begin
      $error("sleep_wakeup_control: unsupported parameters");
    end
  end
  // ***********************************************************
  // declarations
  // ***********************************************************
  sleep_pkg::state_t state; // power state
  logic [2:0] ctrl; // enables
  logic [2:0] irq_status; // sticky events
  logic [2:0] irq_mask; // event gates
  logic [15:0] hold_count; // reset hold ticks
  logic tick; // 1 us enable
  logic [15:0] watchdog_counter; // watchdog count
  logic watchdog_timeout; // one-cycle time-out
  logic pin_changed; // pins differ from snapshot
  logic watchdog_clear; // clear request to watchdog
  logic wake_master; // master clear wake
  logic wake_watchdog; // watchdog wake
  logic wake_pin; // pin change wake
  logic wake_any; // any wake source
  logic sleep_entry; // sleep taken this cycle
  logic run_reset; // reset while running
  logic master_clear_active; // master clear held low and enabled
  logic wr_pending; // write data phase due
  logic [7:0] wr_addr; // latched write address
  logic [2:0] wr_clear; // write-one-to-clear bits
  // ***********************************************************
  // helpers
  // ***********************************************************
  // one decode used for both reads and writes
  function automatic logic addr_is(input logic [31:0] addr, input logic [7:0] offset);
    addr_is = (addr[31:8] == 24'h000000) && (addr[7:0] == offset);
  endfunction
  // ***********************************************************
  // submodules
  // ***********************************************************
  wake_watchdog #(
    .TICK_CYCLES(sleep_pkg::TICK_CYCLES),
    .TIMEOUT_TICKS(WATCHDOG_TICKS)
  ) u_watchdog (
    .clock(clock),
    .rst_n(rst_n),
    .enable(ctrl[sleep_pkg::CTRL_WATCHDOG_EN_BIT]),
    .clear(watchdog_clear),
    .tick(tick),
    .count(watchdog_counter),
    .timeout(watchdog_timeout)
  );
  pin_change_detect #(
    .WIDTH(3)
  ) u_pins (
    .clock(clock),
    .rst_n(rst_n),
    .pins({port_input_three, port_input_one, port_input_zero}),
    .capture(port_access && state == sleep_pkg::ST_RUN),
    .changed(pin_changed)
  );
  // ***********************************************************
  // wake and entry decode
  // ***********************************************************
  assign master_clear_active = ctrl[sleep_pkg::CTRL_MASTER_CLEAR_BIT] && !master_clear_pin_n;
  // only the sleep instruction starts power-down
  // a time-out in the same cycle wins, so entry never races the reset path
  assign sleep_entry = (state == sleep_pkg::ST_RUN) && sleep_exec && !master_clear_active
                       && !watchdog_timeout;
  assign wake_master = (state == sleep_pkg::ST_SLEEP) && master_clear_active;
  assign wake_watchdog = (state == sleep_pkg::ST_SLEEP) && watchdog_timeout;
  // a stale snapshot fires as soon as sleep starts
  assign wake_pin = (state == sleep_pkg::ST_SLEEP) && ctrl[sleep_pkg::CTRL_WAKE_CHANGE_BIT]
                    && pin_changed;
  assign wake_any = wake_master || wake_watchdog || wake_pin;
  assign run_reset = (state == sleep_pkg::ST_RUN) && (master_clear_active || watchdog_timeout);
  // watchdog cleared at entry, by instruction, and on every wake
  assign watchdog_clear = sleep_entry || wake_any
                          || (clrwdt_exec && state == sleep_pkg::ST_RUN);
  // ***********************************************************
  // power state machine
  // ***********************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= sleep_pkg::ST_RUN;
    end else begin
      case (state)
        sleep_pkg::ST_RUN: begin
          if (run_reset) begin
            state <= sleep_pkg::ST_RESET;
          end else if (sleep_entry) begin
            state <= sleep_pkg::ST_SLEEP;
          end
        end
        sleep_pkg::ST_SLEEP: begin
          // no resume path: a wake always goes through reset
          if (wake_any) begin
            state <= sleep_pkg::ST_RESET;
          end
        end
        sleep_pkg::ST_RESET: begin
          if (!master_clear_active && tick && hold_count == 16'(WAKE_RESET_TICKS - 1)) begin
            state <= sleep_pkg::ST_RUN;
          end
        end
        default: begin
          state <= sleep_pkg::ST_RUN;
        end
      endcase
    end
  end
  // reset hold counter, restarted while master clear is held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_count <= 16'h0000;
    end else if (state != sleep_pkg::ST_RESET || master_clear_active) begin
      hold_count <= 16'h0000;
    end else if (tick) begin
      hold_count <= hold_count + 16'h0001;
    end
  end
  // core clock and oscillator follow the state
  assign osc_drive_en = (state != sleep_pkg::ST_SLEEP);
  assign cpu_clock_en = (state == sleep_pkg::ST_RUN);
  assign fetch_hold = (state != sleep_pkg::ST_RUN);
  assign device_reset_n = (state != sleep_pkg::ST_RESET);
  // ***********************************************************
  // pads
  // ***********************************************************
  // drive captured while running, frozen through sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pad_drive <= sleep_pkg::PIN_DRIVE_RESET;
    end else if (state == sleep_pkg::ST_RESET) begin
      pad_drive <= sleep_pkg::PIN_DRIVE_RESET;
    end else if (state == sleep_pkg::ST_RUN && !sleep_entry) begin
      pad_drive <= core_drive;
    end
  end
  // internal resets never pull the master clear pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_oe_n <= 1'b1;
    end else begin
      master_clear_oe_n <= 1'b1;
    end
  end
  // ***********************************************************
  // status flags
  // ***********************************************************
  // power-up value, then only the listed events move them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= sleep_pkg::FLAGS_POWER_UP;
    end else if (wake_master) begin
      flags <= 3'b010;
    end else if (wake_watchdog) begin
      flags <= 3'b000;
    end else if (wake_pin) begin
      flags <= 3'b110;
    end else if (sleep_entry) begin
      flags.timeout <= 1'b1;
      flags.powerdown <= 1'b0;
    end else if (state == sleep_pkg::ST_RUN && !master_clear_active && watchdog_timeout) begin
      flags.timeout <= 1'b0; // powerdown left as is
      flags.pin_wake <= 1'b0;
    end else if (state == sleep_pkg::ST_RUN && clrwdt_exec) begin
      flags.timeout <= 1'b1;
      flags.powerdown <= 1'b1;
    end
  end
  // ***********************************************************
  // ahb-lite slave
  // ***********************************************************
  assign hreadyout = 1'b1; // no wait states
  assign hresp = 1'b0; // always okay
  // address phase: latch write target, answer reads next cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (hready) begin
      wr_pending <= hsel && htrans[1] && hwrite;
      wr_addr <= addr_is(haddr, haddr[7:0]) ? haddr[7:0] : 8'hFF;
      hrdata <= 32'h00000000;
      if (hsel && htrans[1] && !hwrite) begin
        if (addr_is(haddr, sleep_pkg::CTRL_OFFSET)) begin
          hrdata <= {29'h00000000, ctrl};
        end else if (addr_is(haddr, sleep_pkg::STATUS_OFFSET)) begin
          hrdata[sleep_pkg::STATUS_PIN_WAKE_BIT] <= flags.pin_wake;
          hrdata[sleep_pkg::STATUS_TIMEOUT_BIT] <= flags.timeout;
          hrdata[sleep_pkg::STATUS_POWERDOWN_BIT] <= flags.powerdown;
          hrdata[sleep_pkg::STATUS_ASLEEP_BIT] <= (state == sleep_pkg::ST_SLEEP);
        end else if (addr_is(haddr, sleep_pkg::WATCHDOG_OFFSET)) begin
          hrdata <= {16'h0000, watchdog_counter};
        end else if (addr_is(haddr, sleep_pkg::IRQ_STATUS_OFFSET)) begin
          hrdata <= {29'h00000000, irq_status};
        end else if (addr_is(haddr, sleep_pkg::IRQ_MASK_OFFSET)) begin
          hrdata <= {29'h00000000, irq_mask};
        end
      end
    end
  end
  // data phase writes; unmapped addresses are ignored
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= sleep_pkg::CTRL_RESET;
      irq_mask <= sleep_pkg::IRQ_RESET;
    end else if (wr_pending && hready) begin
      if (wr_addr == sleep_pkg::CTRL_OFFSET) begin
        ctrl <= hwdata[2:0];
      end else if (wr_addr == sleep_pkg::IRQ_MASK_OFFSET) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end
  // ***********************************************************
  // interrupts
  // ***********************************************************
  assign wr_clear = (wr_pending && hready && wr_addr == sleep_pkg::IRQ_STATUS_OFFSET) ? hwdata[2:0] : 3'h0;
  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= sleep_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~wr_clear)
                    | {watchdog_timeout, wake_any, sleep_entry};
    end
  end
  assign irq = |(irq_status & irq_mask);
  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_enter;
    state == sleep_pkg::ST_RUN && sleep_exec && !master_clear_active && !watchdog_timeout;
  endsequence
  sequence s_asleep;
    state == sleep_pkg::ST_SLEEP && !osc_drive_en && fetch_hold;
  endsequence
  property p_sleep_entry;
    @(posedge clock) disable iff (!rst_n) s_enter |=> s_asleep;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_only_by_sleep;
    @(posedge clock) disable iff (!rst_n)
      $rose(state == sleep_pkg::ST_SLEEP) |-> $past(sleep_exec);
  endproperty
  a_only_by_sleep: assert property (p_only_by_sleep) else $error("sleep without instruction");
  property p_entry_flags;
    @(posedge clock) disable iff (!rst_n)
      s_enter |=> flags.timeout && !flags.powerdown && watchdog_counter == 16'h0000;
  endproperty
  a_entry_flags: assert property (p_entry_flags) else $error("bad flags at sleep entry");
  property p_pads_frozen;
    @(posedge clock) disable iff (!rst_n)
      state == sleep_pkg::ST_SLEEP && $past(state) == sleep_pkg::ST_SLEEP |-> $stable(pad_drive);
  endproperty
  a_pads_frozen: assert property (p_pads_frozen) else $error("pad drive moved in sleep");
  property p_master_clear_idle;
    @(posedge clock) disable iff (!rst_n) master_clear_oe_n;
  endproperty
  a_master_clear_idle: assert property (p_master_clear_idle) else $error("master clear driven");
  property p_wake_resets;
    @(posedge clock) disable iff (!rst_n)
      wake_any |=> (!device_reset_n && watchdog_counter == 16'h0000) ##1 !device_reset_n;
  endproperty
  a_wake_resets: assert property (p_wake_resets) else $error("wake did not reset");
  property p_watchdog_wake;
    @(posedge clock) disable iff (!rst_n)
      state == sleep_pkg::ST_SLEEP && watchdog_timeout && !master_clear_active |=> flags == 3'b000;
  endproperty
  a_watchdog_wake: assert property (p_watchdog_wake) else $error("watchdog wake flags");
  property p_pin_wake;
    @(posedge clock) disable iff (!rst_n)
      wake_pin && !wake_master && !wake_watchdog |=> flags == 3'b110;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake flags");
  property p_master_wake;
    @(posedge clock) disable iff (!rst_n)
      state == sleep_pkg::ST_SLEEP && master_clear_active |=> state == sleep_pkg::ST_RESET;
  endproperty
  a_master_wake: assert property (p_master_wake) else $error("master clear did not wake");
  property p_hold_in_sleep;
    @(posedge clock) disable iff (!rst_n)
      state == sleep_pkg::ST_SLEEP |-> !cpu_clock_en && device_reset_n;
  endproperty
  a_hold_in_sleep: assert property (p_hold_in_sleep) else $error("core ran in sleep");
endmodule

// >>> test/far_side_model.sv
// ***********************************
// far side: reset pin and port pins
// ***********************************
module far_side_model (
  // clock
  input wire logic clock,
  // commands from the bench
  input wire logic press,
  input wire logic [2:0] toggle,
  // pins seen by the device
  output logic master_clear_pin_n,
  output logic [2:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up on the reset pin, so released reads high
  assign master_clear_pin_n = !press;
  // pins start low
  initial pins = 3'h0;
  // a commanded pin flips at the next edge, as an outside driver would
  always @(posedge clock) begin
    pins <= pins ^ toggle;
  end
endmodule

// >>> test/sleep_wakeup_control_tb.sv
module sleep_wakeup_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ***********************************
  // setup
  // ***********************************
  localparam int WD = 20; // short watchdog
  localparam int HOLD = 3; // short reset hold
  localparam int TC = sleep_pkg::TICK_CYCLES;
  typedef struct {logic [2:0] ctrl; int src; logic [2:0] fl; logic [2:0] ev;} row_t;
  // src: 0 reset pin, 1 pin change, 2 none
  row_t rows [4] = '{'{3'h7, 0, 3'h2, 3'h3}, '{3'h7, 1, 3'h6, 3'h3},
    '{3'h7, 2, 3'h0, 3'h7}, '{3'h5, 1, 3'h0, 3'h7}};
  logic clock = 0;
  logic rst_n = 0;
  logic hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic sleep_exec = 0, clrwdt_exec = 0, port_access = 0, press = 0, mcp_n;
  logic osc_drive_en, cpu_clock_en, fetch_hold, device_reset_n, master_clear_oe_n, irq;
  logic [2:0] toggle = 0, pins;
  sleep_pkg::pin_drive_t core_drive = 12'h5A0, pad_drive;
  sleep_pkg::flags_t flags;
  int miscompares = 0, n_checks = 0, n;
  assign hready = hreadyout; // one slave
  always #25 clock = ~clock;
  sleep_wakeup_control #(.WATCHDOG_TICKS(WD), .WAKE_RESET_TICKS(HOLD)) uut (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_exec(sleep_exec),
    .clrwdt_exec(clrwdt_exec), .port_access(port_access), .core_drive(core_drive), .pad_drive(pad_drive),
    .port_input_zero(pins[0]), .port_input_one(pins[1]), .port_input_three(pins[2]),
    .master_clear_pin_n(mcp_n), .master_clear_oe_n(master_clear_oe_n), .osc_drive_en(osc_drive_en),
    .cpu_clock_en(cpu_clock_en), .fetch_hold(fetch_hold), .device_reset_n(device_reset_n),
    .flags(flags), .irq(irq));
  far_side_model fs (.clock(clock), .press(press), .toggle(toggle), .master_clear_pin_n(mcp_n), .pins(pins));
  // ***********************************
  // tasks
  // ***********************************
  // one comparison, four-state
  task ck(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict and end of run
  task summarize;
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // a wait that ran out
  task stuck;
    miscompares++;
    summarize();
  endtask
  // wait for hready at a rising edge; read data taken at that same edge
  task rdy;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 50);
    q = hrdata;
    if (n >= 50) stuck();
  endtask
  // one single word transfer
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  // one-cycle core event, then a quiet edge
  task pulse_ev(input int which);
    case (which)
      0: sleep_exec <= 1'b1;
      default: port_access <= 1'b1;
    endcase
    @(posedge clock);
    sleep_exec <= 1'b0;
    port_access <= 1'b0;
    @(posedge clock);
  endtask
  // bounded wait for the device reset level
  task wait_rst(input logic lvl, input int lim);
    n = 0;
    while (device_reset_n !== lvl && n < lim) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= lim) stuck();
  endtask
  // reset pin is never driven, checked every cycle
  always @(negedge clock) begin
    if (rst_n) ck("master_clear_pin_oe", master_clear_oe_n, 1'b1);
  end
  // ***********************************
  // sequence
  // ***********************************
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    ck("flags", flags, 3'h3);
    ck("osc", osc_drive_en, 1'b1);
    ck("hresp", hresp, 1'b0);
    bus(0, sleep_pkg::CTRL_OFFSET, 0);
    ck("ctrl", q, 32'h7);
    bus(1, sleep_pkg::STATUS_OFFSET, 32'hFF);
    bus(0, sleep_pkg::STATUS_OFFSET, 0);
    ck("status", q, 32'h18);
    bus(0, 8'h20, 0);
    ck("unmapped", q, 32'h0);
    bus(1, sleep_pkg::IRQ_MASK_OFFSET, 32'h7);
    // one sleep and wake per row; no clear before sleep, so only sleep itself clears the watchdog
    foreach (rows[i]) begin
      bus(1, sleep_pkg::CTRL_OFFSET, {29'h0, rows[i].ctrl});
      core_drive <= 12'h5A0 + 12'(i);
      pulse_ev(1);
      pulse_ev(0);
      #1;
      ck("osc", osc_drive_en, 1'b0);
      ck("cpuclk", cpu_clock_en, 1'b0);
      ck("fetch", fetch_hold, 1'b1);
      ck("to_pd", {flags.timeout, flags.powerdown}, 2'h2);
      ck("pads", pad_drive, 12'h5A0 + 12'(i));
      core_drive <= ~core_drive;
      press <= (rows[i].src == 0);
      toggle <= (rows[i].src == 1) ? 3'h2 : 3'h0;
      @(posedge clock);
      toggle <= 3'h0;
      wait_rst(0, 1000);
      ck("wd_wake", n >= (WD - 2) * TC, rows[i].fl == 3'h0);
      ck("flags", flags, rows[i].fl);
      press <= 1'b0;
      wait_rst(1, 300);
      bus(0, sleep_pkg::WATCHDOG_OFFSET, 0);
      ck("wd_count", q <= HOLD + 2, 1'b1);
      bus(0, sleep_pkg::IRQ_STATUS_OFFSET, 0);
      ck("irq_status", q, {29'h0, rows[i].ev});
      ck("irq", irq, 1'b1);
      bus(1, sleep_pkg::IRQ_STATUS_OFFSET, 32'h7);
      @(posedge clock);
      #1;
      ck("irq", irq, 1'b0);
    end
    // stale snapshot: pin moved after the last port access; wake-on-change back on
    bus(1, sleep_pkg::CTRL_OFFSET, 32'h7);
    pulse_ev(1);
    toggle <= 3'h1;
    @(posedge clock);
    toggle <= 3'h0;
    @(posedge clock);
    pulse_ev(0);
    wait_rst(0, 5);
    ck("stale_flags", flags, 3'h6);
    wait_rst(1, 300);
    // second power-on reset in mid-run restores the power-up flags
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    ck("flags_rst", flags, 3'h3);
    ck("rst_out", device_reset_n, 1'b1);
    bus(0, sleep_pkg::CTRL_OFFSET, 0);
    ck("ctrl_rst", q, 32'h7);
    summarize();
  end
endmodule
